// File: rtl/jtc_top.sv
`timescale 1ns/10ps
`default_nettype none
module jtc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [jtc_pkg::NUM_PADS-1:0] pad_in,
    output logic [jtc_pkg::NUM_PADS-1:0] pad_out,
    output logic [jtc_pkg::NUM_PADS-1:0] pad_oe,
    input wire logic [jtc_pkg::NUM_PADS-1:0] core_out,
    input wire logic [jtc_pkg::NUM_PADS-1:0] core_oe,
    output logic [jtc_pkg::NUM_PADS-1:0] core_in,
    input wire logic rst_pin_n,
    output logic core_rst_n,
    output logic dbg_req_valid,
    output logic [1:0] dbg_req_kind,
    output logic [jtc_pkg::DBG_W-1:0] dbg_req_word,
    input wire logic dbg_rsp_valid,
    input wire logic [jtc_pkg::ACK_W-1:0] dbg_rsp_ack,
    input wire logic [jtc_pkg::ID_W-1:0] dbg_rsp_data
);
    localparam int N = jtc_pkg::NUM_PADS;
    localparam int DW = jtc_pkg::DBG_W;
    localparam int BW = jtc_pkg::BSR_W;

    // =========================================================
    // Test clock reset: power-on reset and test reset pin
    logic [1:0] por_sync_q;
    logic [1:0] trst_sync_q;
    logic tap_rst;

    // Bring both reset sources onto the test clock
    always_ff @(posedge tck) begin
        por_sync_q <= {por_sync_q[0], rst};
        trst_sync_q <= {trst_sync_q[0], trst_n};
    end
    assign tap_rst = por_sync_q[1] | ~trst_sync_q[1];

    // =========================================================
    // Controller state machine
    jtc_pkg::jtc_state_e state_q, state_d;

    // Next state from mode select
    always_comb begin
        case (state_q)
            jtc_pkg::ST_RESET: state_d = tms ? jtc_pkg::ST_RESET
                                             : jtc_pkg::ST_IDLE;
            jtc_pkg::ST_IDLE: state_d = tms ? jtc_pkg::ST_SEL_DR
                                            : jtc_pkg::ST_IDLE;
            jtc_pkg::ST_SEL_DR: state_d = tms ? jtc_pkg::ST_SEL_IR
                                              : jtc_pkg::ST_CAP_DR;
            jtc_pkg::ST_CAP_DR: state_d = tms ? jtc_pkg::ST_EX1_DR
                                              : jtc_pkg::ST_SH_DR;
            jtc_pkg::ST_SH_DR: state_d = tms ? jtc_pkg::ST_EX1_DR
                                             : jtc_pkg::ST_SH_DR;
            jtc_pkg::ST_EX1_DR: state_d = tms ? jtc_pkg::ST_UPD_DR
                                              : jtc_pkg::ST_PAU_DR;
            jtc_pkg::ST_PAU_DR: state_d = tms ? jtc_pkg::ST_EX2_DR
                                              : jtc_pkg::ST_PAU_DR;
            jtc_pkg::ST_EX2_DR: state_d = tms ? jtc_pkg::ST_UPD_DR
                                              : jtc_pkg::ST_SH_DR;
            jtc_pkg::ST_UPD_DR: state_d = tms ? jtc_pkg::ST_SEL_DR
                                              : jtc_pkg::ST_IDLE;
            jtc_pkg::ST_SEL_IR: state_d = tms ? jtc_pkg::ST_RESET
                                              : jtc_pkg::ST_CAP_IR;
            jtc_pkg::ST_CAP_IR: state_d = tms ? jtc_pkg::ST_EX1_IR
                                              : jtc_pkg::ST_SH_IR;
            jtc_pkg::ST_SH_IR: state_d = tms ? jtc_pkg::ST_EX1_IR
                                             : jtc_pkg::ST_SH_IR;
            jtc_pkg::ST_EX1_IR: state_d = tms ? jtc_pkg::ST_UPD_IR
                                              : jtc_pkg::ST_PAU_IR;
            jtc_pkg::ST_PAU_IR: state_d = tms ? jtc_pkg::ST_EX2_IR
                                              : jtc_pkg::ST_PAU_IR;
            jtc_pkg::ST_EX2_IR: state_d = tms ? jtc_pkg::ST_UPD_IR
                                              : jtc_pkg::ST_SH_IR;
            jtc_pkg::ST_UPD_IR: state_d = tms ? jtc_pkg::ST_SEL_DR
                                              : jtc_pkg::ST_IDLE;
            default: state_d = jtc_pkg::ST_RESET;
        endcase
    end

    // State register, forced to logic reset by either reset
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            state_q <= jtc_pkg::ST_RESET; // [R22]
        end else begin
            state_q <= state_d; // [R22]
        end
    end

    // =========================================================
    // Instruction shift chain and holding register
    logic [jtc_pkg::IR_W-1:0] ir_sh_q;
    logic [jtc_pkg::IR_W-1:0] ir_q;

    // Capture fixed pattern, shift in from the data input
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            ir_sh_q <= jtc_pkg::IR_CAPTURE;
        end else if (state_q == jtc_pkg::ST_CAP_IR) begin
            ir_sh_q <= jtc_pkg::IR_CAPTURE; // [R23]
        end else if (state_q == jtc_pkg::ST_SH_IR) begin
            ir_sh_q <= {tdi, ir_sh_q[jtc_pkg::IR_W-1:1]}; // [R1] [R20]
        end
    end

    // Active instruction changes only at update or in logic reset
    always_ff @(posedge tck) begin
        if (tap_rst || state_q == jtc_pkg::ST_RESET) begin
            ir_q <= jtc_pkg::IR_IDCODE; // [R17]
        end else if (state_q == jtc_pkg::ST_UPD_IR) begin
            ir_q <= ir_sh_q; // [R1] [R2]
        end
    end

    // =========================================================
    // Instruction decode
    logic sel_bsr, sel_dbg, sel_id, sel_byp, mode_ext, mode_int;
    jtc_pkg::jtc_kind_e kind;

    // Decode, with every other code falling back to bypass
    always_comb begin
        mode_ext = (ir_q == jtc_pkg::IR_EXTEST); // [R3]
        mode_int = (ir_q == jtc_pkg::IR_INTEST); // [R3]
        sel_bsr = mode_ext | mode_int | (ir_q == jtc_pkg::IR_SAMPLE); // [R9]
        sel_id = (ir_q == jtc_pkg::IR_IDCODE); // [R5]
        sel_dbg = 1'b1;
        kind = jtc_pkg::KIND_ABORT;
        case (ir_q)
            jtc_pkg::IR_ABORT: kind = jtc_pkg::KIND_ABORT; // [R4]
            jtc_pkg::IR_DBG_PORT: kind = jtc_pkg::KIND_DP; // [R4]
            jtc_pkg::IR_ACC_PORT: kind = jtc_pkg::KIND_AP; // [R4]
            default: sel_dbg = 1'b0;
        endcase
        sel_byp = ~(sel_bsr | sel_id | sel_dbg); // [R5] [R6]
    end

    // =========================================================
    // Boundary cells and pad steering
    logic [BW-1:0] bsr_upd_q;
    logic [BW-1:0] samp_raw;
    logic [BW-1:0] samp_s1_q, samp_s2_q;

    // Per pad: cell order input, output, enable from nearest pad
    generate
        for (genvar p = 0; p < N; p++) begin : g_pad
            assign pad_out[p] = mode_ext ?
                bsr_upd_q[3*p+jtc_pkg::CELL_OUT] : core_out[p]; // [R7]
            assign pad_oe[p] = mode_ext ?
                bsr_upd_q[3*p+jtc_pkg::CELL_OE] : core_oe[p]; // [R7]
            assign core_in[p] = mode_int ?
                bsr_upd_q[3*p+jtc_pkg::CELL_IN] : pad_in[p]; // [R8]
            assign samp_raw[3*p+jtc_pkg::CELL_IN] = pad_in[p]; // [R13]
            assign samp_raw[3*p+jtc_pkg::CELL_OUT] = pad_out[p]; // [R13]
            assign samp_raw[3*p+jtc_pkg::CELL_OE] = pad_oe[p]; // [R13]
        end
    endgenerate
    assign samp_raw[jtc_pkg::RST_CELL] = rst_pin_n;
    // Reset pin is only observed, never forced
    assign core_rst_n = rst_pin_n; // [R10]

    // Pad values arrive from outside the test clock
    always_ff @(posedge tck) begin
        samp_s1_q <= samp_raw;
        samp_s2_q <= samp_s1_q;
    end

    // =========================================================
    // Debug response crossing into the test clock
    logic [DW-1:0] rsp_q;
    logic rsp_tgl_q;
    logic [2:0] rsp_sync_q;
    logic [DW-1:0] rsp_hold_q;

    // Hold the response word and flag it by toggle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp_q <= '0;
            rsp_tgl_q <= 1'b0;
        end else if (dbg_rsp_valid) begin
            rsp_q <= {dbg_rsp_data, dbg_rsp_ack};
            rsp_tgl_q <= ~rsp_tgl_q;
        end
    end

    // Copy the stable response word after the toggle arrives
    always_ff @(posedge tck) begin
        rsp_sync_q <= {rsp_sync_q[1:0], rsp_tgl_q};
        if (tap_rst) begin
            rsp_hold_q <= '0;
        end else if (rsp_sync_q[2] != rsp_sync_q[1]) begin
            rsp_hold_q <= rsp_q; // [R16]
        end
    end

    // =========================================================
    // Shared data chain
    logic [DW-1:0] dr_sh_q;
    logic [DW-1:0] dr_nxt;
    logic [5:0] dr_len;

    // Chain length for the selected register
    always_comb begin
        if (sel_dbg) begin
            dr_len = 6'(DW); // [R14]
        end else if (sel_bsr) begin
            dr_len = 6'(BW);
        end else if (sel_id) begin
            dr_len = 6'(jtc_pkg::ID_W); // [R18]
        end else begin
            dr_len = 6'h01; // [R19]
        end
    end

    // Shift toward bit 0, input enters at the chain's top stage
    generate
        for (genvar i = 0; i < DW; i++) begin : g_dr
            if (i == DW - 1) begin : g_top
                assign dr_nxt[i] = (6'(i) == dr_len - 6'h01) ? tdi : 1'b0;
            end else begin : g_mid
                assign dr_nxt[i] = (6'(i) == dr_len - 6'h01) ?
                    tdi : dr_sh_q[i+1];
            end
        end
    endgenerate

    // Capture and shift of the selected chain
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            dr_sh_q <= '0;
        end else if (state_q == jtc_pkg::ST_CAP_DR) begin
            if (sel_dbg) begin
                dr_sh_q <= rsp_hold_q; // [R16]
            end else if (sel_bsr) begin
                dr_sh_q <= DW'(samp_s2_q); // [R11]
            end else if (sel_id) begin
                dr_sh_q <= DW'(jtc_pkg::ID_VALUE); // [R18]
            end else begin
                dr_sh_q <= '0; // [R19]
            end
        end else if (state_q == jtc_pkg::ST_SH_DR) begin
            dr_sh_q <= dr_nxt; // [R12] [R20]
        end
    end

    // Preload registers take the shifted boundary data on update
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            bsr_upd_q <= '0;
        end else if (state_q == jtc_pkg::ST_UPD_DR && sel_bsr) begin
            bsr_upd_q <= dr_sh_q[BW-1:0]; // [R12]
        end
    end

    // =========================================================
    // Debug request crossing to the reference clock
    logic [DW-1:0] req_word_q;
    logic [1:0] req_kind_q;
    logic req_tgl_q;

    // Launch request at update of an access or abort chain
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            req_word_q <= '0;
            req_kind_q <= 2'h0;
            req_tgl_q <= 1'b0;
        end else if (state_q == jtc_pkg::ST_UPD_DR && sel_dbg) begin
            req_word_q <= dr_sh_q; // [R15] [R16]
            req_kind_q <= kind;
            req_tgl_q <= ~req_tgl_q;
        end
    end

    logic [2:0] req_sync_q;
    logic req_new;
    assign req_new = req_sync_q[2] != req_sync_q[1];

    // Detect toggle, then latch the word, which is stable by now
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_sync_q <= 3'h0;
            dbg_req_valid <= 1'b0;
            dbg_req_kind <= 2'h0;
            dbg_req_word <= '0;
        end else begin
            req_sync_q <= {req_sync_q[1:0], req_tgl_q};
            dbg_req_valid <= req_new; // [R15]
            if (req_new) begin
                dbg_req_kind <= req_kind_q;
                dbg_req_word <= req_word_q;
            end
        end
    end

    // =========================================================
    // Data output on the falling edge
    logic tdo_q, tdo_oe_q;

    // Drive only while shifting, else stay quiet
    always_ff @(negedge tck) begin
        if (tap_rst) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= (state_q == jtc_pkg::ST_SH_IR) ?
                ir_sh_q[0] : dr_sh_q[0]; // [R20]
            tdo_oe_q <= (state_q == jtc_pkg::ST_SH_IR) ||
                (state_q == jtc_pkg::ST_SH_DR); // [R21]
        end
    end
    assign tdo = tdo_q & tdo_oe_q;
    assign tdo_oe = tdo_oe_q;

    // =========================================================
    // Checks
    a_ir_reset_load: assert property ( // [R17]
        @(posedge tck) disable iff (tap_rst)
        state_q == jtc_pkg::ST_RESET |=> ir_q == jtc_pkg::IR_IDCODE)
        else $error("instruction not identification after reset");
    a_ir_update_only: assert property ( // [R2]
        @(posedge tck) disable iff (tap_rst)
        state_q != jtc_pkg::ST_UPD_IR && state_q != jtc_pkg::ST_RESET
        |=> $stable(ir_q))
        else $error("instruction changed outside update");
    a_ir_capture_pat: assert property ( // [R23]
        @(posedge tck) disable iff (tap_rst)
        state_q == jtc_pkg::ST_CAP_IR |=> ir_sh_q[1:0] == 2'h1)
        else $error("instruction capture pattern wrong");
    a_bypass_zero: assert property ( // [R19]
        @(posedge tck) disable iff (tap_rst)
        state_q == jtc_pkg::ST_CAP_DR && sel_byp |=> dr_sh_q[0] == 1'b0)
        else $error("bypass capture not zero");
    a_id_capture: assert property ( // [R18]
        @(posedge tck) disable iff (tap_rst)
        state_q == jtc_pkg::ST_CAP_DR && sel_id
        |=> dr_sh_q[31:0] == jtc_pkg::ID_VALUE && dr_sh_q[0])
        else $error("identification capture wrong");
    a_ext_pad_drive: assert property ( // [R7]
        @(posedge tck) disable iff (tap_rst)
        ir_q == jtc_pkg::IR_EXTEST |-> pad_out[0] == bsr_upd_q[1]
        && pad_oe[0] == bsr_upd_q[2])
        else $error("external test not driving pad");
    a_int_core_drive: assert property ( // [R8]
        @(posedge tck) disable iff (tap_rst)
        ir_q == jtc_pkg::IR_INTEST |-> core_in[0] == bsr_upd_q[0])
        else $error("internal test not driving core");
    a_rst_observe: assert property ( // [R10]
        @(posedge tck) disable iff (tap_rst)
        core_rst_n == rst_pin_n)
        else $error("core reset forced by boundary cell");
    a_tdo_idle: assert property ( // [R21]
        @(posedge tck) disable iff (tap_rst)
        (state_q != jtc_pkg::ST_SH_IR && state_q != jtc_pkg::ST_SH_DR) [*2]
        |-> !tdo_oe)
        else $error("data output driven while idle");
    a_dbg_launch: assert property ( // [R15]
        @(posedge tck) disable iff (tap_rst)
        state_q == jtc_pkg::ST_UPD_DR && sel_dbg
        |=> req_tgl_q != $past(req_tgl_q))
        else $error("debug request not launched");
    a_bsr_preload: assert property ( // [R12]
        @(posedge tck) disable iff (tap_rst)
        state_q == jtc_pkg::ST_UPD_DR && sel_bsr
        |=> bsr_upd_q == dr_sh_q[BW-1:0])
        else $error("preload cells not updated from chain");
    a_dbg_capture: assert property ( // [R16]
        @(posedge tck) disable iff (tap_rst)
        state_q == jtc_pkg::ST_CAP_DR && sel_dbg
        |=> dr_sh_q == $past(rsp_hold_q))
        else $error("debug chain capture not last response");
endmodule : jtc_top
`default_nettype wire

// File: inc/jtc_pkg.sv
// Function
// R1 - Instruction register is a 4-bit shift chain with a parallel holding register.
// R2 - Holding register becomes the active instruction only at instruction update.
// R3 - Codes 0000 external test, 0001 internal test, 0010 sample/preload.
// R4 - Codes 1000 abort, 1010 debug-port access, 1011 access-port access.
// R5 - Code 1110 identification readout, 1111 bypass with one shift stage.
// R6 - Every unassigned code behaves exactly like bypass.
// R7 - External test drives pads from preloaded output and enable cells.
// R8 - Internal test drives core inputs from preloaded input cells.
// R9 - Under external or internal test the boundary chain stays selected.
// R10 - Reset pin cell is observe-only; core reset never driven from preload.
// R11 - Sample/preload captures every pad input, output, enable in capture.
// R12 - Shift moves captured values out, update copies into preload registers.
// R13 - Boundary chain starts at nearest pad, cells input, output, enable.
// R14 - Abort, debug-port and access-port chains are 35 bits each.
// R15 - Abort chain data clears sticky errors or aborts outstanding request.
// R16 - Access chains reach debug registers and internal buses via the unit.
// R17 - Identification code loaded on power-on, test reset and logic reset.
// R18 - Identification chain is 32 bits with a fixed code, LSB 1.
// R19 - Bypass chain is a single stage capturing 0.
// R20 - Data input sampled on rising, data output changed on falling edge.
// R21 - Data output is inactive whenever not shifting.
// R22 - Controller enters logic reset on resets; tester steps it by mode select.
// R23 - Instruction capture loads a fixed pattern ending in binary 01.
`default_nettype none
package jtc_pkg;
    // =========================================================
    // Chain sizes
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam int DBG_W = 35;
    localparam int ACK_W = 3;
    localparam int NUM_PADS = 8;
    localparam int BSR_W = 3 * NUM_PADS + 1;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;
    localparam int RST_CELL = 3 * NUM_PADS;
    localparam int SYNC_W = 2;

    // =========================================================
    // Instruction codes and reset values
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_INTEST = 4'h1;
    localparam logic [3:0] IR_SAMPLE = 4'h2;
    localparam logic [3:0] IR_ABORT = 4'h8;
    localparam logic [3:0] IR_DBG_PORT = 4'ha;
    localparam logic [3:0] IR_ACC_PORT = 4'hb;
    localparam logic [3:0] IR_IDCODE = 4'he;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h5;
    // Identification value is arbitrary; LSB must stay 1
    localparam logic [31:0] ID_VALUE = 32'h0abc_d001;

    // =========================================================
    // Controller states and debug request kinds
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3, ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5,
        ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7, ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
        ST_EX1_IR = 4'hc, ST_PAU_IR = 4'hd, ST_EX2_IR = 4'he,
        ST_UPD_IR = 4'hf
    } jtc_state_e;

    typedef enum logic [1:0] {
        KIND_ABORT = 2'h0, KIND_DP = 2'h1, KIND_AP = 2'h2
    } jtc_kind_e;
endpackage : jtc_pkg
`default_nettype wire

// File: tb/jtc_tester.sv
`timescale 1ns/10ps
`default_nettype none
// Test port driver; the test clock runs only inside frames
module jtc_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo
);
    // Idle levels: clock low, data at its pull-up level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;
    end

    // One test clock cycle of 6 ns; output read just before the rise
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #3;
        o = tdo;
        tck = 1'b1;
        #3;
        tck = 1'b0;
    endtask : tick

    // Run-test idle for n cycles
    task automatic idle(input int n);
        logic o;
        repeat (n) tick(1'b0, 1'b1, o);
    endtask : idle

    // Five mode-select highs reach logic reset, then go to idle
    task automatic reset_tap();
        logic o;
        repeat (5) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask : reset_tap

    // Test reset pin held low for four cycles, then back to idle
    task automatic pin_reset();
        logic o;
        trst_n = 1'b0;
        repeat (4) tick(1'b1, 1'b1, o);
        trst_n = 1'b1;
        reset_tap();
    endtask : pin_reset

    // Scan n bits LSB first through instruction or data path, from idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b1, o);
        if (ir) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask : scan
endmodule : jtc_tester
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, ac) begin \
    check_count++; \
    if ((ac) !== (ex)) begin \
        $display("BAD %s exp %0h seen %0h", nm, ex, ac); \
        error_cnt++; \
    end \
end
module testbench;
    typedef struct {
        logic [3:0] ir;
        int len;
        logic [63:0] cap;
        logic dbg;
        logic [1:0] kind;
    } jtc_row_s;
    localparam logic [63:0] PAT = 64'hd3c1_96e5_a7b4_2f18;
    localparam logic [24:0] PRE = 25'h1b4_c3a5;
    localparam logic [31:0] RSP_DATA = 32'h5a5a_c3c3;
    localparam logic [2:0] RSP_ACK = 3'h2;
    logic ref_clk = 1'b0, rst = 1'b1, tck, tms, tdi, trst_n, tdo, tdo_oe;
    logic [7:0] pad_in = 8'h3c, core_out = 8'ha5, core_oe = 8'h0f;
    logic [7:0] pad_out, pad_oe, core_in;
    logic rst_pin_n = 1'b1, core_rst_n, dbg_req_valid, dbg_rsp_valid = 1'b0;
    logic [1:0] dbg_req_kind;
    logic [34:0] dbg_req_word;
    logic [2:0] dbg_rsp_ack = 3'h0;
    logic [31:0] dbg_rsp_data = 32'h0;
    logic [63:0] dout;
    jtc_row_s rows [14];
    int error_cnt = 0, check_count = 0, req_cnt = 0, n0;

    always #4 ref_clk = ~ref_clk;

    jtc_top i_dut (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
        .rst_pin_n(rst_pin_n), .core_rst_n(core_rst_n),
        .dbg_req_valid(dbg_req_valid), .dbg_req_kind(dbg_req_kind),
        .dbg_req_word(dbg_req_word), .dbg_rsp_valid(dbg_rsp_valid),
        .dbg_rsp_ack(dbg_rsp_ack), .dbg_rsp_data(dbg_rsp_data));
    // Pull-up holds the data output line high while it is released
    logic tdo_pin;
    assign tdo_pin = tdo_oe ? tdo : 1'b1;
    jtc_tester i_tst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo(tdo_pin));

    // Counts request pulses towards the debug unit
    always @(posedge ref_clk) begin
        if (dbg_req_valid === 1'b1) req_cnt <= req_cnt + 1;
    end

    // Boundary image: pad p at 3p input, 3p+1 output, 3p+2 enable
    function automatic logic [24:0] bsr_of(input logic [7:0] i, o, e,
                                           input logic r);
        logic [24:0] v;
        v[jtc_pkg::RST_CELL] = r;
        for (int p = 0; p < 8; p++) begin
            v[3 * p + jtc_pkg::CELL_IN] = i[p];
            v[3 * p + jtc_pkg::CELL_OUT] = o[p];
            v[3 * p + jtc_pkg::CELL_OE] = e[p];
        end
        return v;
    endfunction : bsr_of

    // Picks one kind of cell out of a boundary image
    function automatic logic [7:0] cells(input logic [24:0] b, input int off);
        logic [7:0] v;
        for (int p = 0; p < 8; p++) v[p] = b[3 * p + off];
        return v;
    endfunction : cells

    // Expected chain for an instruction code
    function automatic jtc_row_s mk(input logic [3:0] ir);
        jtc_row_s r;
        logic [63:0] dcap;
        dcap = {29'h0, RSP_DATA, RSP_ACK};
        r = '{ir, 1, 64'h0, 1'b0, 2'h0};
        case (ir)
            jtc_pkg::IR_SAMPLE: r = '{ir, 25, {39'h0, bsr_of(pad_in,
                core_out, core_oe, rst_pin_n)}, 1'b0, 2'h0};
            jtc_pkg::IR_ABORT: r = '{ir, 35, dcap, 1'b1, 2'h0};
            jtc_pkg::IR_DBG_PORT: r = '{ir, 35, dcap, 1'b1, 2'h1};
            jtc_pkg::IR_ACC_PORT: r = '{ir, 35, dcap, 1'b1, 2'h2};
            jtc_pkg::IR_IDCODE: r = '{ir, 32, {32'h0, jtc_pkg::ID_VALUE},
                1'b0, 2'h0};
            default: r = r;
        endcase
        return r;
    endfunction : mk

    // Prints counts and verdict, then stops
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // Watchdog well beyond the expected run of about 10 us
    initial begin
        #300000;
        error_cnt++;
        test_done();
    end

    // =====================================================
    // Main sequence
    initial begin
        fork
            repeat (6) @(negedge ref_clk);
            i_tst.reset_tap();
        join
        rst = 1'b0;
        i_tst.reset_tap();
        @(negedge ref_clk);
        dbg_rsp_valid = 1'b1;
        dbg_rsp_data = RSP_DATA;
        dbg_rsp_ack = RSP_ACK;
        @(negedge ref_clk);
        dbg_rsp_valid = 1'b0;
        i_tst.idle(6);
        for (int c = 0; c < 14; c++) rows[c] = mk(4'(c + 2));
        // Every code from 2 up: chain length, capture and requests
        foreach (rows[k]) begin
            i_tst.scan(1'b1, 4, {60'h0, rows[k].ir}, dout);
            `CHK("ir_capture", jtc_pkg::IR_CAPTURE, dout[3:0])
            n0 = req_cnt;
            i_tst.scan(1'b0, 64, PAT, dout);
            `CHK("dr_out", (PAT << rows[k].len) | rows[k].cap, dout)
            repeat (10) @(negedge ref_clk);
            `CHK("req_count", n0 + int'(rows[k].dbg), req_cnt)
            if (rows[k].dbg) begin
                `CHK("req_kind", rows[k].kind, dbg_req_kind)
                `CHK("req_word", PAT[63:29], dbg_req_word)
            end
        end
        $display("test code_table done");
        // Preload, then external and internal test
        i_tst.scan(1'b1, 4, {60'h0, jtc_pkg::IR_SAMPLE}, dout);
        i_tst.scan(1'b0, 25, {39'h0, PRE}, dout);
        i_tst.scan(1'b1, 4, {60'h0, jtc_pkg::IR_EXTEST}, dout);
        `CHK("pad_out", cells(PRE, jtc_pkg::CELL_OUT), pad_out)
        `CHK("pad_oe", cells(PRE, jtc_pkg::CELL_OE), pad_oe)
        `CHK("core_in_ext", pad_in, core_in)
        i_tst.scan(1'b1, 4, {60'h0, jtc_pkg::IR_INTEST}, dout);
        `CHK("core_in", cells(PRE, jtc_pkg::CELL_IN), core_in)
        `CHK("pad_out_int", core_out, pad_out)
        @(negedge ref_clk);
        rst_pin_n = 1'b0;
        i_tst.idle(3);
        `CHK("core_rst", 1'b0, core_rst_n)
        i_tst.scan(1'b0, 25, 64'h0, dout);
        `CHK("rst_cell", 1'b0, dout[24])
        rst_pin_n = 1'b1;
        $display("test boundary done");
        // Both reset paths restore the identification chain
        i_tst.scan(1'b1, 4, {60'h0, jtc_pkg::IR_BYPASS}, dout);
        i_tst.pin_reset();
        i_tst.scan(1'b0, 64, PAT, dout);
        `CHK("id_trst", (PAT << 32) | jtc_pkg::ID_VALUE, dout)
        i_tst.scan(1'b1, 4, {60'h0, jtc_pkg::IR_BYPASS}, dout);
        i_tst.reset_tap();
        i_tst.scan(1'b0, 64, PAT, dout);
        `CHK("id_tms", (PAT << 32) | jtc_pkg::ID_VALUE, dout)
        // Power-on reset again in mid-run, test clock kept running
        i_tst.scan(1'b1, 4, {60'h0, jtc_pkg::IR_BYPASS}, dout);
        n0 = req_cnt;
        @(negedge ref_clk);
        rst = 1'b1;
        fork
            repeat (6) @(negedge ref_clk);
            i_tst.idle(4);
        join
        rst = 1'b0;
        i_tst.reset_tap();
        i_tst.scan(1'b0, 64, PAT, dout);
        `CHK("id_por", (PAT << 32) | jtc_pkg::ID_VALUE, dout)
        `CHK("req_quiet", n0, req_cnt)
        `CHK("tdo_oe_idle", 1'b0, tdo_oe)
        `CHK("tdo_idle", 1'b0, tdo)
        $display("test resets done");
        test_done();
    end
endmodule : testbench
`undef CHK
`default_nettype wire
